// ==== design/otc_pkg.sv ====
// Package for the oscillator trim and compensation register bank.
// Assumes a single 125 MHz core clock and an 8-bit register port.
`default_nettype none
package otc_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] ADDR_INIT_TRIM = 8'h0B;
  localparam logic [7:0] ADDR_CURVATURE = 8'h0C;
  localparam logic [7:0] ADDR_COMP_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_FINAL_ANALOG = 8'h0E;
  localparam logic [7:0] ADDR_FINAL_DIGITAL = 8'h0F;
  localparam logic [7:0] ADDR_TEMP_RESULT = 8'h20;
  localparam int BIT_SENSE_EN = 7;
  localparam int BIT_BAT_EN = 6;
  localparam int BIT_BAT_RATE = 5;
  localparam logic [7:0] CTRL_WR_MASK = 8'hE0;
  localparam logic [5:0] ANALOG_ZERO_CODE = 6'h20;
  localparam logic [1:0] DIG_TRIM_OFF = 2'h0;
  localparam logic [1:0] DIG_TRIM_PLUS = 2'h1;
  localparam logic [1:0] DIG_TRIM_ZERO = 2'h2;
  localparam logic [1:0] DIG_TRIM_MINUS = 2'h3;
  localparam int ALPHA_SCALE_LOG2 = 11;
  localparam int SLOW_PERIOD_MIN = 10;
  localparam int FAST_PERIOD_MIN = 1;
  localparam int SEC_PER_MIN = 60;
  localparam int CONV_TIME_MS = 22;
  localparam int TEMP_ROOM = 10'h1F4;
  typedef struct packed {
    logic sense_en;
    logic bat_en;
    logic bat_rate;
  } otc_ctrl_t;
  typedef struct packed {
    logic [5:0] analog;
    logic [4:0] digital;
  } otc_trim_t;
  typedef enum logic [1:0] {
    OTC_IDLE = 2'b00,
    OTC_CONV1 = 2'b01,
    OTC_CONV2 = 2'b10,
    OTC_APPLY = 2'b11
  } otc_state_t;
endpackage
`default_nettype wire

// ==== design/otc_conv_timer.sv ====
// Conversion timer: times one temperature conversion.
// Assumes start is a one-cycle pulse on the core clock.
`default_nettype none
module otc_conv_timer #(
  parameter int CYCLES = 2750000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  logic [31:0] cnt_r;
  logic busy_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
    end else if (start) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 32'h1;
      if (cnt_r == 32'(CYCLES - 1)) begin
        busy_r <= 1'b0;
      end
    end
  end
  assign done = busy_r && (cnt_r == 32'(CYCLES - 1));
endmodule // otc_conv_timer
`default_nettype wire

// ==== design/otc_regs.sv ====
// Oscillator trim and temperature compensation registers with sequencing.
// Assumes factory values are static pins and battery indications are asynchronous pins from outside.
// Behaviour
// (RQ1) Analog trim code 0 is +32 ppm, 0x20 is 0, 0x3F is -31 ppm.
// (RQ2) Initial analog trim loads from factory store and ignores host writes.
// (RQ3) Initial trim register: digital trim bits 7:6, analog trim bits 5:0.
// (RQ4) Curvature register holds magnitude of cold coefficient times 2048, unsigned.
// (RQ5) Curvature loads from factory store and ignores host writes.
// (RQ6) Control register writes change only bits 7:5; gain bits stay factory.
// (RQ7) Sense enable resets to 0; setting it enables sensing and trim adjustment.
// (RQ8) With sense disabled the initial trims drive frequency control.
// (RQ9) Setting sense enable runs two conversions and stores their average.
// (RQ10) Battery compensation enable resets to 0; 1 compensates on battery.
// (RQ11) Battery-low below 2.7 V suppresses battery compensation.
// (RQ12) Battery rate 0 gives 10 minute interval, 1 gives 1 minute.
// (RQ13) Digital trim: 00 off, 01 +30.5, 10 zero, 11 -30.5 ppm, read-only.
// (RQ14) Active compensation derives final trims from temperature, curvature, gain; the final digital trim copies the initial one.
`default_nettype none
module otc_regs
  import otc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_TIME_MS * CLK_MHZ * 1000,
  parameter longint MIN_CYCLES = longint'(SEC_PER_MIN) * CLK_MHZ * 1000000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [5:0] fuse_analog_trim,
  input wire logic [1:0] fuse_digital_trim,
  input wire logic [7:0] fuse_curvature,
  input wire logic [4:0] fuse_step_gain,
  input wire logic on_battery,
  input wire logic battery_low,
  input wire logic [9:0] temp_sample,
  output otc_trim_t trim_out,
  output logic sensor_on
);
  logic bat_s1_r, bat_s2_r, low_s1_r, low_s2_r;
  logic [5:0] init_analog_r;
  logic [1:0] init_digital_r;
  logic [7:0] curvature_r;
  logic [4:0] gain_r;
  otc_ctrl_t ctrl_r;
  otc_state_t state_r, state_nxt;
  logic [9:0] samp1_r, temp_r;
  otc_trim_t final_r, trim_r;
  logic [7:0] rdata_r;
  logic [35:0] min_cnt_r;
  logic [3:0] min_tick_r;
  logic conv_done, conv_start;

  always_ff @(posedge core_clk) begin
    bat_s1_r <= on_battery;
    bat_s2_r <= bat_s1_r;
    low_s1_r <= battery_low;
    low_s2_r <= low_s1_r;
  end

  // The final digital trim is sign and magnitude: bit 4 marks a negative step.
  function automatic logic [4:0] dig_ppm_steps(input logic [1:0] code);
    dig_ppm_steps = (code == DIG_TRIM_PLUS) ? 5'h01 : (code == DIG_TRIM_MINUS) ? 5'h11 : 5'h00; // [RQ13]
  endfunction

  // Factory values are recalled on every cycle that reset is held and never written by the host.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      init_analog_r <= fuse_analog_trim; // [RQ2]
      init_digital_r <= fuse_digital_trim; // [RQ13]
      curvature_r <= fuse_curvature; // [RQ5]
      gain_r <= fuse_step_gain; // [RQ6]
    end
  end

  wire ctrl_wr = wr_en && (addr == ADDR_COMP_CTRL);
  wire [7:0] ctrl_byte = {ctrl_r.sense_en, ctrl_r.bat_en, ctrl_r.bat_rate, gain_r};
  wire [7:0] ctrl_merged = (wdata & CTRL_WR_MASK) | (ctrl_byte & ~CTRL_WR_MASK); // [RQ6]
  // A start on battery needs the newly written battery enable and no battery-low indication.
  wire start_ok_new = !bat_s2_r || (wdata[BIT_BAT_EN] && !low_s2_r); // [RQ11]
  wire sense_rise = ctrl_wr && wdata[BIT_SENSE_EN] && !ctrl_r.sense_en && start_ok_new; // [RQ9] [RQ11]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= '0; // [RQ7] [RQ10]
    end else if (ctrl_wr) begin
      ctrl_r <= otc_ctrl_t'(ctrl_merged[BIT_SENSE_EN:BIT_BAT_RATE]);
    end
  end

  // Battery-mode interval timer, counted in minutes.
  wire bat_comp_ok = ctrl_r.bat_en && !low_s2_r; // [RQ11]
  wire [3:0] interval_min = ctrl_r.bat_rate ? 4'(FAST_PERIOD_MIN) : 4'(SLOW_PERIOD_MIN); // [RQ12]
  wire min_pulse = (min_cnt_r == 36'(MIN_CYCLES - 1));
  wire bat_due = bat_s2_r && bat_comp_ok && min_pulse && (min_tick_r + 4'h1 >= interval_min); // [RQ12]

  always_ff @(posedge core_clk) begin
    if (rst || !bat_s2_r || !bat_comp_ok) begin
      min_cnt_r <= 36'h0;
      min_tick_r <= 4'h0;
    end else if (min_pulse) begin
      min_cnt_r <= 36'h0;
      min_tick_r <= bat_due ? 4'h0 : min_tick_r + 4'h1;
    end else begin
      min_cnt_r <= min_cnt_r + 36'h1;
    end
  end

  // On VDD, sensing is held by the enable; on battery it also needs the battery enable.
  wire sense_allowed = ctrl_r.sense_en && (!bat_s2_r || bat_comp_ok); // [RQ7] [RQ10] [RQ11]
  wire start_req = sense_rise || (bat_due && ctrl_r.sense_en); // [RQ9]

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OTC_IDLE: if (start_req) state_nxt = OTC_CONV1;
      OTC_CONV1: if (conv_done) state_nxt = OTC_CONV2;
      OTC_CONV2: if (conv_done) state_nxt = OTC_APPLY;
      OTC_APPLY: state_nxt = OTC_IDLE;
    endcase
    if (!sense_allowed && !sense_rise) begin
      state_nxt = OTC_IDLE;
    end
  end

  assign conv_start = (state_r == OTC_IDLE && state_nxt == OTC_CONV1) || (state_r == OTC_CONV1 && conv_done);
  assign sensor_on = (state_r == OTC_CONV1) || (state_r == OTC_CONV2); // [RQ7]

  otc_conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(conv_start),
    .done(conv_done)
  );

  // Curvature correction: alpha * dT^2 / 2048, scaled by the step gain.
  wire signed [10:0] dtemp = $signed({1'b0, temp_r}) - $signed(11'(TEMP_ROOM));
  wire [21:0] dsq = 22'($signed(dtemp) * $signed(dtemp));
  wire [29:0] curve_ppm = 30'((dsq * curvature_r) >> ALPHA_SCALE_LOG2) >> 4; // [RQ4] [RQ14]
  wire [11:0] gain_mult = 12'h10 + {7'h0, gain_r[4], 4'h0} + {8'h0, gain_r[3:0]};
  wire [41:0] corr_full = 42'(curve_ppm) * 42'(gain_mult);
  wire [7:0] corr = (corr_full[41:4] > 38'h3F) ? 8'h3F : 8'(corr_full[11:4]); // [RQ14]
  wire signed [8:0] ana = $signed({3'b0, init_analog_r}) - $signed({1'b0, corr}); // [RQ1] [RQ14]
  wire [5:0] ana_sat = ana < 0 ? 6'h00 : 6'(ana);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= OTC_IDLE;
      samp1_r <= 10'h0;
      temp_r <= 10'(TEMP_ROOM);
      final_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == OTC_CONV1 && conv_done) samp1_r <= temp_sample;
      if (state_r == OTC_CONV2 && conv_done) temp_r <= 10'((11'(samp1_r) + 11'(temp_sample)) >> 1); // [RQ9]
      if (state_r == OTC_APPLY) final_r <= '{analog: ana_sat, digital: 5'(dig_ppm_steps(init_digital_r))}; // [RQ14]
    end
  end

  // Frequency control source: initial trims unless compensation is active.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trim_r <= '0;
    end else if (sense_allowed) begin
      trim_r <= final_r; // [RQ14]
    end else begin
      trim_r <= '{analog: init_analog_r, digital: 5'(dig_ppm_steps(init_digital_r))}; // [RQ8]
    end
  end
  assign trim_out = trim_r;

  wire [7:0] rd_mux =
    (addr == ADDR_INIT_TRIM) ? {init_digital_r, init_analog_r} : // [RQ3]
    (addr == ADDR_CURVATURE) ? curvature_r : // [RQ4]
    (addr == ADDR_COMP_CTRL) ? ctrl_byte :
    (addr == ADDR_FINAL_ANALOG) ? {2'h0, final_r.analog} :
    (addr == ADDR_FINAL_DIGITAL) ? {3'h0, final_r.digital} :
    (addr == ADDR_TEMP_RESULT) ? temp_r[9:2] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_en ? rd_mux : 8'h00;
    end
  end
  assign rdata = rdata_r;
endmodule // otc_regs
`default_nettype wire

// ==== bench/otc_regs_props.sv ====
// Checker for the trim register bank.
// Assumes it is bound to otc_regs and sees only its ports.
`default_nettype none
module otc_regs_props
  import otc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [5:0] fuse_analog_trim,
  input wire logic [1:0] fuse_digital_trim,
  input wire logic [7:0] fuse_curvature,
  input wire logic [4:0] fuse_step_gain,
  input wire logic on_battery,
  input wire logic battery_low,
  input wire otc_trim_t trim_out,
  input wire logic sensor_on
);
  logic [2:0] ctrl_r;
  always_ff @(posedge core_clk)
    if (rst) ctrl_r <= 3'h0;
    else if (wr_en && addr == ADDR_COMP_CTRL) ctrl_r <= wdata[7:5];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a); rd_en && addr == a; endsequence
  sequence s_off; !ctrl_r[2] && !$past(rst) && !$past(rst, 2); endsequence
  chk_init_read: assert property (s_rd(ADDR_INIT_TRIM) |=> rdata == {fuse_digital_trim, fuse_analog_trim})
    else $error("bad trim read");
  chk_curv_read: assert property (s_rd(ADDR_CURVATURE) |=> rdata == fuse_curvature)
    else $error("bad curvature read");
  chk_gain_keep: assert property (s_rd(ADDR_COMP_CTRL) |=> rdata[4:0] == fuse_step_gain)
    else $error("bad gain bits");
  chk_ctrl_read: assert property (s_rd(ADDR_COMP_CTRL) |=> rdata[7:5] == $past(ctrl_r))
    else $error("bad control bits");
  chk_idle_analog: assert property (s_off [*2] |-> trim_out.analog == fuse_analog_trim)
    else $error("analog trim not initial");
  chk_idle_digital: assert property (s_off [*2] |-> trim_out.digital ==
    (fuse_digital_trim == 2'h1 ? 5'h01 : fuse_digital_trim == 2'h3 ? 5'h11 : 5'h00)) else $error("bad digital trim");
  chk_sense_start: assert property ($rose(ctrl_r[2]) && !on_battery |-> ##[0:3] sensor_on)
    else $error("no conversion");
  chk_low_quiet: assert property ((on_battery && battery_low) [*4] |-> !$rose(sensor_on))
    else $error("conversion on low battery");
endmodule // otc_regs_props
bind otc_regs otc_regs_props i_props (.core_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .fuse_analog_trim,
  .fuse_digital_trim, .fuse_curvature, .fuse_step_gain, .on_battery, .battery_low, .trim_out, .sensor_on);
`default_nettype wire

// ==== bench/otc_regs_tb_top.sv ====
// Self-checking bench for the trim register bank.
// Assumes the checker binds itself to the design.
`default_nettype none
module otc_regs_tb_top
  import otc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = '0, rst = '1, wr_en = '0, rd_en = '0, on_battery = '0, battery_low = '0, sensor_on, s_q;
  logic [7:0] addr = '0, wdata = '0, rdata, fuse_curvature = '0;
  logic [5:0] fuse_analog_trim = '0;
  logic [1:0] fuse_digital_trim = '0;
  logic [4:0] fuse_step_gain = '0;
  logic [9:0] temp_sample = '0;
  logic [5:0] at [4] = '{6'h00, 6'h20, 6'h3F, 6'h15};
  otc_trim_t trim_out;
  int n_errors = 0, checks = 0, cyc = 0, n_rise = 0, last = 0, gap = 0, m_ctrl = 0, n;
  otc_regs #(.CONV_CYCLES(10), .MIN_CYCLES(100)) i_dut (.core_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .fuse_analog_trim, .fuse_digital_trim, .fuse_curvature, .fuse_step_gain, .on_battery, .battery_low,
    .temp_sample, .trim_out, .sensor_on);
  initial forever #4 core_clk = ~core_clk;
  task automatic test_done();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    s_q <= sensor_on;
    if (sensor_on === 1'h1 && s_q === 1'h0) begin
      n_rise++;
      gap = cyc - last;
      last = cyc;
    end
    if (cyc > 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic cmp(input string s, input logic [10:0] e, input logic [10:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [7:0] model(input logic [7:0] a);
    case (a)
      ADDR_INIT_TRIM: return {fuse_digital_trim, fuse_analog_trim};
      ADDR_CURVATURE: return fuse_curvature;
      ADDR_COMP_CTRL: return {m_ctrl[2:0], fuse_step_gain};
      ADDR_TEMP_RESULT: return temp_sample[9:2];
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_en <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'h0;
    if (a == ADDR_COMP_CTRL) m_ctrl = d[7:5];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'h0;
    #1 cmp("rdata", {3'h0, model(a)}, {3'h0, rdata});
  endtask
  initial begin
    void'($urandom(80));
    for (int i = 0; i < 4; i++) begin
      rst <= 1'h1;
      fuse_analog_trim <= at[i];
      fuse_digital_trim <= 2'(i);
      fuse_curvature <= 8'($urandom);
      fuse_step_gain <= 5'($urandom);
      m_ctrl = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      rd(ADDR_COMP_CTRL);
      repeat (3) begin
        wr(ADDR_INIT_TRIM, 8'($urandom));
        wr(ADDR_CURVATURE, 8'($urandom));
        wr(ADDR_COMP_CTRL, 8'($urandom) & 8'h7F);
        wr(8'h30, 8'($urandom));
        rd(ADDR_INIT_TRIM);
        rd(ADDR_CURVATURE);
        rd(ADDR_COMP_CTRL);
        rd(8'h30);
      end
      cmp("analog", 11'(at[i]), 11'(trim_out.analog));
      cmp("digital", i == 1 ? 11'h01 : i == 3 ? 11'h11 : 11'h00, 11'(trim_out.digital));
      $display("test fuse set %0d done", i);
    end
    temp_sample <= 10'($urandom);
    wr(ADDR_COMP_CTRL, 8'h80);
    wait (n_rise == 1);
    repeat (40) @(posedge core_clk);
    rd(ADDR_TEMP_RESULT);
    wr(ADDR_COMP_CTRL, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 cmp("analog", 11'(at[3]), 11'(trim_out.analog));
    $display("test sensing done");
    on_battery <= 1'h1;
    battery_low <= 1'h1;
    repeat (3) @(posedge core_clk);
    n = n_rise;
    wr(ADDR_COMP_CTRL, 8'hE0);
    repeat (1500) @(posedge core_clk);
    cmp("low rises", 11'(n), 11'(n_rise));
    battery_low <= 1'h0;
    for (int k = 1; k < 11; k += 9) begin
      wr(ADDR_COMP_CTRL, k == 1 ? 8'hE0 : 8'hC0);
      n = n_rise;
      wait (n_rise == n + 3);
      cmp("period", 11'h1, 11'(gap > 100 * k - 40 && gap < 100 * k + 40));
    end
    $display("test battery done");
    test_done();
  end
endmodule // otc_regs_tb_top
`default_nettype wire
